// ===== design/alu_flags_pkg.sv
// constants, register map and operation codes for the alu with status flags
package alu_flags_pkg;
	localparam int REG_W = 40;
	localparam int RF_DEPTH = 16;
	localparam int ADDR_W = 12;
	localparam logic [11:0] OFF_MODE = 12'h000;
	localparam logic [11:0] OFF_ASTAT = 12'h004;
	localparam logic [11:0] OFF_STKY = 12'h008;
	localparam logic [11:0] OFF_CMD = 12'h00C;
	localparam logic [11:0] OFF_RF = 12'h100;
	localparam logic [31:0] MODE_RESET = 32'h0001_0000;
	localparam int MODE_SAT = 13;
	localparam int MODE_ROUND_TO_ZERO_SELECT = 15;
	localparam int MODE_SHORT = 16;
	localparam int FLAG_Z = 0;
	localparam int FLAG_V = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_C = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_I = 5;
	localparam int FLAG_F = 10;
	localparam int COMPARE_HISTORY_LO = 24;
	localparam int COMPARE_HISTORY_HI = 31;
	localparam int STK_US = 0;
	localparam int STK_VS = 1;
	localparam int STK_OS = 2;
	localparam int STK_IS = 5;
	localparam logic [31:0] SAT_POS = 32'h7FFF_FFFF;
	localparam logic [31:0] SAT_NEG = 32'h8000_0000;
	localparam logic [39:0] FNAN = 40'hFF_FFFF_FFFF;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [2:0] DEC_NONE = 3'h0;
	localparam logic [2:0] DEC_MODE = 3'h1;
	localparam logic [2:0] DEC_ASTAT = 3'h2;
	localparam logic [2:0] DEC_STKY = 3'h3;
	localparam logic [2:0] DEC_CMD = 3'h4;
	localparam logic [2:0] DEC_RFHI = 3'h5;
	localparam logic [2:0] DEC_RFLO = 3'h6;
	localparam logic [5:0] OP_ADD = 6'h00;
	localparam logic [5:0] OP_SUB = 6'h01;
	localparam logic [5:0] OP_ADDC = 6'h02;
	localparam logic [5:0] OP_SUBB = 6'h03;
	localparam logic [5:0] OP_AVG = 6'h04;
	localparam logic [5:0] OP_COMP = 6'h05;
	localparam logic [5:0] OP_COMPU = 6'h06;
	localparam logic [5:0] OP_ADDCI = 6'h07;
	localparam logic [5:0] OP_DECCI = 6'h08;
	localparam logic [5:0] OP_INC = 6'h09;
	localparam logic [5:0] OP_DEC = 6'h0A;
	localparam logic [5:0] OP_NEG = 6'h0B;
	localparam logic [5:0] OP_ABS = 6'h0C;
	localparam logic [5:0] OP_PASS = 6'h0D;
	localparam logic [5:0] OP_AND = 6'h0E;
	localparam logic [5:0] OP_OR = 6'h0F;
	localparam logic [5:0] OP_XOR = 6'h10;
	localparam logic [5:0] OP_NOT = 6'h11;
	localparam logic [5:0] OP_MIN = 6'h12;
	localparam logic [5:0] OP_MAX = 6'h13;
	localparam logic [5:0] OP_CLIP = 6'h14;
	localparam logic [5:0] OP_ADDSUB = 6'h15;
	localparam logic [5:0] OP_FPASS = 6'h20;
	localparam logic [5:0] OP_FNEG = 6'h21;
	localparam logic [5:0] OP_FABS = 6'h22;
	localparam logic [5:0] OP_FCOMP = 6'h23;
	localparam logic [5:0] OP_FLOGB = 6'h24;
	localparam logic [5:0] OP_FMANT = 6'h25;
	localparam logic [5:0] OP_FSCALB = 6'h26;
	localparam logic [5:0] OP_FIX = 6'h27;
endpackage : alu_flags_pkg

// ===== design/alu_flags_saturation.sv
// alu with status and sticky flags, register file and axi4-lite slave
module alu_flags_saturation import alu_flags_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready
);
	logic [REG_W-1:0] rf [RF_DEPTH];
	logic [31:0] mode_reg, arith_reg, sticky_reg, cmd_reg;
	logic aw_full_reg, w_full_reg, issue_reg, ex_valid_reg, wr_fire;
	logic [11:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic [2:0] wd, rd;
	logic [3:0] wr_idx, ex_rn_reg, ex_rm_reg;
	logic [5:0] ex_op_reg;
	logic [39:0] ex_x_reg, ex_y_reg, xf, yf, res1, res2, r40;
	logic mode_wr, astat_wr, stky_wr, cmd_wr, rfhi_wr, rflo_wr;
	logic sat_en, round_to_zero_select, short, ci;
	logic [31:0] fx_x, fx_y, a_in, b_in, r32, r2, lim, rd_mux, sty_set;
	logic c_in, arith_op, op_ok, wr1, wr2, fixed, cmp, gt, pos_only;
	logic f_z, f_v, f_n, f_c, f_s, f_i;
	logic [33:0] ar, ng, ar2;
	logic [32:0] s33;
	logic [33:0] ne;
	logic [9:0] e_s;
	logic [63:0] wide;
	logic [31:0] ip;
	logic xnan, ynan, xzero;

	function automatic logic [2:0] dec(input logic [11:0] a);
		logic [2:0] d;
		d = DEC_NONE;
		if (a[11:7] == OFF_RF[11:7] && a[1:0] == 2'h0)
			d = a[2] ? DEC_RFLO : DEC_RFHI;
		else if (a == OFF_MODE)
			d = DEC_MODE;
		else if (a == OFF_ASTAT)
			d = DEC_ASTAT;
		else if (a == OFF_STKY)
			d = DEC_STKY;
		else if (a == OFF_CMD)
			d = DEC_CMD;
		return d;
	endfunction : dec

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (s[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		return r;
	endfunction : merge

	// two's complement add: {overflow, carry, sum}
	function automatic logic [33:0] arith(input logic [31:0] a,
		input logic [31:0] b, input logic c);
		logic [32:0] s;
		s = {1'b0, a} + {1'b0, b} + {32'h0, c};
		return {(a[31] == b[31]) && (s[31] != a[31]), s[32], s[31:0]};
	endfunction : arith

	function automatic logic [31:0] sat(input logic [33:0] r,
		input logic en);
		if (en && r[33])
			return r[31] ? SAT_POS : SAT_NEG;
		return r[31:0];
	endfunction : sat

	// short mode drops the low byte; denormals flush to zero
	function automatic logic [39:0] fin(input logic [39:0] v,
		input logic sh);
		logic [39:0] r;
		r = sh ? {v[39:8], 8'h00} : v;
		if (r[38:31] == 8'h00)
			r = '0;
		return r;
	endfunction : fin

	function automatic logic [39:0] fkey(input logic [39:0] v);
		return v[39] ? ~v : {1'b1, v[38:0]};
	endfunction : fkey

	// axi write channels, taken in either order
	assign wr_fire = aw_full_reg && w_full_reg && !bvalid;
	assign wd = dec(aw_addr_reg);
	assign wr_idx = aw_addr_reg[6:3];
	assign mode_wr = wr_fire && wd == DEC_MODE;
	assign astat_wr = wr_fire && wd == DEC_ASTAT;
	assign stky_wr = wr_fire && wd == DEC_STKY;
	assign cmd_wr = wr_fire && wd == DEC_CMD;
	assign rfhi_wr = wr_fire && wd == DEC_RFHI;
	assign rflo_wr = wr_fire && wd == DEC_RFLO;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			aw_full_reg <= 1'b0;
			awready <= 1'b1;
			aw_addr_reg <= '0;
		end else if (awvalid && awready) begin
			aw_full_reg <= 1'b1;
			awready <= 1'b0;
			aw_addr_reg <= awaddr;
		end else if (wr_fire) begin
			aw_full_reg <= 1'b0;
			awready <= 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			w_full_reg <= 1'b0;
			wready <= 1'b1;
			w_data_reg <= '0;
			w_strb_reg <= '0;
		end else if (wvalid && wready) begin
			w_full_reg <= 1'b1;
			wready <= 1'b0;
			w_data_reg <= wdata;
			w_strb_reg <= wstrb;
		end else if (wr_fire) begin
			w_full_reg <= 1'b0;
			wready <= 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid <= 1'b1;
			bresp <= (wd == DEC_NONE) ? RESP_SLVERR : RESP_OKAY;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// axi read channel
	assign rd = dec(araddr);
	always_comb begin
		rd_mux = 32'h0;
		case (rd)
			DEC_MODE: rd_mux = mode_reg;
			DEC_ASTAT: rd_mux = arith_reg;
			DEC_STKY: rd_mux = sticky_reg;
			DEC_CMD: rd_mux = cmd_reg;
			DEC_RFHI: rd_mux = rf[araddr[6:3]][39:8];
			DEC_RFLO: rd_mux = {24'h0, rf[araddr[6:3]][7:0]};
			default: rd_mux = 32'h0;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rd_mux;
			rresp <= (rd == DEC_NONE) ? RESP_SLVERR : RESP_OKAY;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

	// mode control and command
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode_reg <= MODE_RESET;
			cmd_reg <= '0;
			issue_reg <= 1'b0;
		end else begin
			if (mode_wr)
				mode_reg <= merge(mode_reg, w_data_reg, w_strb_reg);
			if (cmd_wr)
				cmd_reg <= merge(cmd_reg, w_data_reg, w_strb_reg);
			issue_reg <= cmd_wr;
		end
	end
	assign sat_en = mode_reg[MODE_SAT];
	assign round_to_zero_select = mode_reg[MODE_ROUND_TO_ZERO_SELECT];
	assign short = mode_reg[MODE_SHORT];
	assign ci = arith_reg[FLAG_C];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ex_valid_reg <= 1'b0;
			ex_op_reg <= '0;
			ex_x_reg <= '0;
			ex_y_reg <= '0;
			ex_rn_reg <= '0;
			ex_rm_reg <= '0;
		end else begin
			ex_valid_reg <= issue_reg;
			if (issue_reg) begin
				ex_op_reg <= cmd_reg[5:0];
				ex_x_reg <= rf[cmd_reg[11:8]];
				ex_y_reg <= rf[cmd_reg[15:12]];
				ex_rn_reg <= cmd_reg[19:16];
				ex_rm_reg <= cmd_reg[23:20];
			end
		end
	end

	assign fx_x = ex_x_reg[39:8];
	assign fx_y = ex_y_reg[39:8];
	// float inputs narrowed in short mode
	assign xf = fin(ex_x_reg, short);
	assign yf = fin(ex_y_reg, short);
	assign xzero = xf[38:31] == 8'h00;
	assign xnan = xf[38:31] == 8'hFF && xf[30:0] != 31'h0;
	assign ynan = yf[38:31] == 8'hFF && yf[30:0] != 31'h0;

	always_comb begin
		a_in = fx_x;
		b_in = fx_y;
		c_in = 1'b0;
		arith_op = 1'b1;
		case (ex_op_reg)
			OP_ADD: c_in = 1'b0;
			OP_SUB: begin
				b_in = ~fx_y;
				c_in = 1'b1;
			end
			OP_ADDC: c_in = ci;
			OP_SUBB: begin
				b_in = ~fx_y;
				c_in = ci;
			end
			OP_ADDCI: begin
				b_in = 32'h0;
				c_in = ci;
			end
			OP_DECCI: begin
				b_in = 32'hFFFF_FFFF;
				c_in = ci;
			end
			OP_INC: begin
				b_in = 32'h0;
				c_in = 1'b1;
			end
			OP_DEC: b_in = 32'hFFFF_FFFF;
			OP_NEG: begin
				a_in = 32'h0;
				b_in = ~fx_x;
				c_in = 1'b1;
			end
			default: arith_op = 1'b0;
		endcase
	end
	assign ar = arith(a_in, b_in, c_in);
	assign ng = arith(32'h0, ~fx_x, 1'b1);
	assign ar2 = arith(fx_x, ~fx_y, 1'b1);
	assign s33 = {fx_x[31], fx_x} + {fx_y[31], fx_y};
	assign lim = fx_y[31] ? 32'h0 - fx_y : fx_y;
	assign ne = {26'h0, xf[38:31]} + {{2{fx_y[31]}}, fx_y};
	assign e_s = {2'h0, xf[38:31]} - 10'd127;
	assign wide = {1'b1, xf[30:0], 32'h0} >> (6'd31 - e_s[5:0]);

	always_comb begin
		r32 = 32'h0;
		r2 = 32'h0;
		r40 = 40'h0;
		ip = 32'h0;
		op_ok = 1'b1;
		wr1 = 1'b1;
		wr2 = 1'b0;
		fixed = !ex_op_reg[5];
		cmp = 1'b0;
		gt = 1'b0;
		pos_only = 1'b0;
		f_z = 1'b0;
		f_v = 1'b0;
		f_n = 1'b0;
		f_c = 1'b0;
		f_s = 1'b0;
		f_i = 1'b0;
		sty_set = 32'h0;
		if (arith_op) begin
			r32 = sat(ar, sat_en);
			f_v = ar[33];
			f_c = ar[32];
			sty_set[STK_OS] = ar[33];
		end else begin
			case (ex_op_reg)
				OP_ADDSUB: begin
					r32 = sat(arith(fx_x, fx_y, 1'b0), sat_en);
					r2 = sat(ar2, sat_en);
					wr2 = 1'b1;
					f_v = ar[33] || ar2[33];
					f_c = ar[32];
					sty_set[STK_OS] = f_v;
				end
				OP_AVG: begin
					r32 = s33[32:1];
					if (!round_to_zero_select && s33[0] && s33[1])
						r32 = s33[32:1] + 32'h1;
					f_c = ar[32];
				end
				OP_ABS: begin
					r32 = fx_x[31] ? sat(ng, sat_en) : fx_x;
					f_v = fx_x[31] && ng[33];
					f_s = fx_x[31];
					pos_only = 1'b1;
					sty_set[STK_OS] = f_v;
				end
				OP_PASS: r32 = fx_x;
				OP_AND: r32 = fx_x & fx_y;
				OP_OR: r32 = fx_x | fx_y;
				OP_XOR: r32 = fx_x ^ fx_y;
				OP_NOT: r32 = ~fx_x;
				OP_MIN: r32 = ($signed(fx_x) < $signed(fx_y)) ? fx_x : fx_y;
				OP_MAX: r32 = ($signed(fx_x) > $signed(fx_y)) ? fx_x : fx_y;
				OP_CLIP: begin
					r32 = fx_x;
					if ($signed(fx_x) > $signed(lim))
						r32 = lim;
					else if ($signed(fx_x) < -$signed(lim))
						r32 = 32'h0 - lim;
				end
				OP_COMP, OP_COMPU: begin
					cmp = 1'b1;
					wr1 = 1'b0;
					gt = ex_op_reg == OP_COMP ?
						$signed(fx_x) > $signed(fx_y) : fx_x > fx_y;
					f_z = fx_x == fx_y;
					f_n = !gt && !f_z;
				end
				OP_FPASS: r40 = xf;
				OP_FNEG: r40 = {!xf[39], xf[38:0]};
				OP_FABS: begin
					r40 = {1'b0, xf[38:0]};
					f_s = xf[39];
				end
				OP_FCOMP: begin
					cmp = 1'b1;
					wr1 = 1'b0;
					gt = !xnan && !ynan && fkey(xf) > fkey(yf);
					f_z = !xnan && !ynan && xf == yf;
					f_n = !xnan && !ynan && fkey(xf) < fkey(yf);
					f_i = ynan;
				end
				OP_FLOGB: begin
					fixed = 1'b1;
					r32 = {{22{e_s[9]}}, e_s};
					if (xzero || xf[38:31] == 8'hFF) begin
						r32 = xzero ? SAT_NEG : SAT_POS;
						f_v = 1'b1;
						sty_set[STK_VS] = 1'b1;
					end
				end
				OP_FMANT: begin
					fixed = 1'b1;
					r32 = xzero ? 32'h0 : {1'b1, xf[30:0]};
					f_s = xf[39];
					pos_only = 1'b1;
				end
				OP_FSCALB: begin
					r40 = {xf[39], ne[7:0], xf[30:0]};
					if (xzero)
						r40 = xf;
					else if ($signed(ne) >= 34'sd255) begin
						r40 = round_to_zero_select ? {xf[39], 8'hFE, 31'h7FFF_FFFF}
							: {xf[39], 8'hFF, 31'h0};
						f_v = 1'b1;
						sty_set[STK_VS] = 1'b1;
					end else if ($signed(ne) <= 34'sd0) begin
						r40 = {xf[39], 39'h0};
						f_z = 1'b1;
						sty_set[STK_US] = 1'b1;
					end
				end
				OP_FIX: begin
					fixed = 1'b1;
					ip = wide[63:32];
					if ($signed(e_s) < -10'sd32 || xzero)
						ip = 32'h0;
					else if (!round_to_zero_select && wide[31] &&
						(wide[30:0] != 31'h0 || ip[0]))
						ip = ip + 32'h1;
					r32 = xf[39] ? 32'h0 - ip : ip;
					if ($signed(e_s) > 10'sd30 || ip[31]) begin
						r32 = xf[39] ? SAT_NEG : SAT_POS;
						f_v = 1'b1;
						sty_set[STK_VS] = 1'b1;
					end
					sty_set[STK_US] = !xzero && ip == 32'h0;
				end
				default: begin
					op_ok = 1'b0;
					wr1 = 1'b0;
				end
			endcase
		end
		if (!fixed) begin
			f_i = f_i || xnan;
			if (xnan)
				r40 = FNAN;
		end else if (ex_op_reg[5])
			f_i = xnan;
		sty_set[STK_IS] = f_i;
		res2 = {r2, 8'h00};
		if (fixed) begin
			res1 = {r32, 8'h00};
			if (!cmp) begin
				f_z = r32 == 32'h0;
				f_n = r32[31] && !pos_only;
			end
		end else begin
			// short mode truncates to 32 bits, zeroing the low byte
			res1 = short ? {r40[39:8], 8'h00} : r40;
			if (!cmp) begin
				f_z = f_z || r40[38:31] == 8'h00;
				f_n = r40[39];
			end
		end
	end

	// write-back to any register; bus writes win a clash
	always_ff @(posedge clk) begin
		if (ex_valid_reg && wr1)
			rf[ex_rn_reg] <= res1;
		if (ex_valid_reg && wr2)
			rf[ex_rm_reg] <= res2;
		if (rfhi_wr)
			rf[wr_idx][39:8] <= merge(rf[wr_idx][39:8], w_data_reg, w_strb_reg);
		if (rflo_wr && w_strb_reg[0])
			rf[wr_idx][7:0] <= w_data_reg[7:0];
	end

	// flags update at end of op cycle unless software writes
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			arith_reg <= '0;
		else if (astat_wr)
			arith_reg <= merge(arith_reg, w_data_reg, w_strb_reg);
		else if (ex_valid_reg && op_ok) begin
			arith_reg[FLAG_Z] <= f_z;
			arith_reg[FLAG_V] <= f_v;
			arith_reg[FLAG_N] <= f_n;
			arith_reg[FLAG_C] <= f_c;
			arith_reg[FLAG_S] <= f_s;
			arith_reg[FLAG_I] <= f_i;
			arith_reg[FLAG_F] <= ex_op_reg[5];
			if (cmp)
				arith_reg[COMPARE_HISTORY_HI:COMPARE_HISTORY_LO] <= {gt, arith_reg[COMPARE_HISTORY_HI:COMPARE_HISTORY_LO+1]};
		end
	end

	// ops only ever set sticky bits; a software write can set or clear them
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			sticky_reg <= '0;
		else if (stky_wr)
			sticky_reg <= merge(sticky_reg, w_data_reg, w_strb_reg);
		else if (ex_valid_reg && op_ok)
			sticky_reg <= sticky_reg | sty_set;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_sat_positive: assert property (
		ex_valid_reg && arith_op && sat_en && ar[33] && ar[31]
		|=> rf[$past(ex_rn_reg)][39:8] == SAT_POS || $past(wr_fire))
		else $error("positive overflow not clamped");
	a_sat_off_raw: assert property (
		ex_valid_reg && arith_op && !sat_en |-> res1[39:8] == ar[31:0])
		else $error("unsaturated result altered");
	a_low_byte_zero: assert property (
		ex_valid_reg && wr1 && fixed |-> res1[7:0] == 8'h00)
		else $error("fixed result low byte not zero");
	a_sticky_keeps: assert property (
		!stky_wr |=> (sticky_reg & $past(sticky_reg)) == $past(sticky_reg))
		else $error("sticky bit cleared by operation");
	a_compare_history_only_cmp: assert property (
		!(ex_valid_reg && cmp) && !astat_wr
		|=> $stable(arith_reg[COMPARE_HISTORY_HI:COMPARE_HISTORY_LO]))
		else $error("compare history moved without compare");
	a_cmd_flag_time: assert property (
		cmd_wr ##1 !astat_wr ##1 (op_ok && !astat_wr)
		|=> arith_reg[FLAG_F] == $past(ex_op_reg[5]))
		else $error("float flag not updated two cycles after issue");
	a_write_wins: assert property (
		astat_wr && ex_valid_reg && w_strb_reg == 4'hF
		|=> arith_reg == $past(w_data_reg))
		else $error("status write lost to flag update");
	a_logic_clears: assert property (
		ex_valid_reg && !astat_wr && ex_op_reg >= OP_AND
		&& ex_op_reg <= OP_NOT
		|=> !arith_reg[FLAG_V] && !arith_reg[FLAG_C] && !arith_reg[FLAG_F])
		else $error("logic op left overflow or carry set");
	a_abs_not_neg: assert property (
		ex_valid_reg && !astat_wr && ex_op_reg == OP_ABS
		|=> !arith_reg[FLAG_N] && arith_reg[FLAG_S] == $past(fx_x[31]))
		else $error("abs negative or sign flag wrong");
	a_cmp_no_write: assert property (
		ex_valid_reg && cmp |-> !wr1 && !wr2)
		else $error("compare wrote a result");
	a_carry_used: assert property (
		ex_valid_reg && ex_op_reg == OP_ADDC && !sat_en
		|-> res1[39:8] == fx_x + fx_y + 32'(arith_reg[FLAG_C]))
		else $error("add with carry ignored carry flag");
endmodule : alu_flags_saturation

// ===== verification/axi_master.sv
// axi4-lite master model standing in for the software side
module axi_master import alu_flags_pkg::*; (
	input wire logic clk,
	output logic [ADDR_W-1:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	output logic [ADDR_W-1:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		awaddr = '0;
		awvalid = 1'b0;
		wdata = '0;
		wstrb = 4'hF;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = '0;
		arvalid = 1'b0;
		rready = 1'b0;
	end
	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic aw;
		logic w;
		logic b;
		aw = 1'b1;
		w = 1'b1;
		b = 1'b1;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (b) begin
			@(posedge clk);
			if (aw && awready) begin
				aw = 1'b0;
				awvalid <= 1'b0;
			end
			if (w && wready) begin
				w = 1'b0;
				wvalid <= 1'b0;
			end
			if (bvalid) begin
				r = bresp;
				b = 1'b0;
				bready <= 1'b0;
			end
		end
	endtask : wr
	task automatic rd(input logic [11:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic ar;
		logic rw;
		ar = 1'b1;
		rw = 1'b1;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (rw) begin
			@(posedge clk);
			if (ar && arready) begin
				ar = 1'b0;
				arvalid <= 1'b0;
			end
			if (rvalid) begin
				d = rdata;
				r = rresp;
				rw = 1'b0;
				rready <= 1'b0;
			end
		end
	endtask : rd
endmodule : axi_master

// ===== verification/testbench.sv
// self-checking bench for the alu with status flags
module testbench import alu_flags_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	int fail_count = 0;
	int n_checks = 0;
	alu_flags_saturation i_dut (.clk, .rst, .awaddr, .awvalid, .awready,
		.wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
		.arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
	axi_master i_mst (.clk, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready);
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wreg(input logic [11:0] a, input logic [31:0] d);
		logic [1:0] r;
		i_mst.wr(a, d, r);
		chk("bresp", 32'(RESP_OKAY), 32'(r));
	endtask : wreg
	task automatic rreg(input string nm, input logic [11:0] a,
		input logic [31:0] e);
		logic [31:0] v;
		logic [1:0] r;
		i_mst.rd(a, v, r);
		chk(nm, e, v);
	endtask : rreg
	function automatic logic [11:0] hi(input int i);
		return OFF_RF + 12'(8 * i);
	endfunction : hi
	function automatic logic [31:0] cmd(input logic [5:0] op, input int x,
		input int y, input int d);
		return {12'h000, d[3:0], y[3:0], x[3:0], 2'h0, op};
	endfunction : cmd
	task automatic t_reset();
		logic [31:0] v;
		logic [1:0] r;
		rreg("mode", OFF_MODE, MODE_RESET);
		rreg("astat", OFF_ASTAT, 32'h0000_0000);
		rreg("stky", OFF_STKY, 32'h0000_0000);
		i_mst.wr(12'h050, 32'h1234_5678, r);
		chk("unmapped bresp", 32'(RESP_SLVERR), 32'(r));
		i_mst.rd(12'h050, v, r);
		chk("unmapped rresp", 32'(RESP_SLVERR), 32'(r));
		chk("unmapped rdata", 32'h0000_0000, v);
	endtask : t_reset
	task automatic t_sat();
		wreg(hi(0), SAT_POS);
		wreg(hi(1), 32'h0000_0001);
		wreg(hi(3), SAT_NEG);
		wreg(hi(4), 32'hFFFF_FFFF);
		wreg(OFF_MODE, MODE_RESET | 32'h0000_2000);
		wreg(OFF_CMD, cmd(OP_ADD, 0, 1, 2));
		rreg("sat pos", hi(2), SAT_POS);
		rreg("low byte", hi(2) + 12'h004, 32'h0000_0000);
		rreg("sticky fixed ov", OFF_STKY, 32'h0000_0004);
		wreg(OFF_CMD, cmd(OP_ADD, 3, 4, 5));
		rreg("sat neg", hi(5), SAT_NEG);
	endtask : t_sat
	task automatic t_wrap();
		wreg(OFF_MODE, MODE_RESET);
		wreg(OFF_CMD, cmd(OP_ADD, 0, 1, 2));
		rreg("wrap pos", hi(2), SAT_NEG);
		rreg("astat v n", OFF_ASTAT, 32'h0000_0006);
		wreg(OFF_CMD, cmd(OP_ADD, 3, 4, 5));
		rreg("wrap neg", hi(5), SAT_POS);
		rreg("astat v c", OFF_ASTAT, 32'h0000_000A);
		wreg(OFF_CMD, cmd(OP_SUBB, 1, 1, 6));
		rreg("subb", hi(6), 32'h0000_0000);
		rreg("astat z c", OFF_ASTAT, 32'h0000_0009);
		wreg(OFF_CMD, cmd(OP_ADDC, 1, 1, 6));
		rreg("addc", hi(6), 32'h0000_0003);
	endtask : t_wrap
	task automatic t_logic();
		wreg(OFF_CMD, cmd(OP_AND, 0, 0, 7));
		rreg("and", hi(7), SAT_POS);
		rreg("astat and", OFF_ASTAT, 32'h0000_0000);
		wreg(OFF_CMD, cmd(OP_CLIP, 0, 4, 7));
		rreg("clip", hi(7), 32'h0000_0001);
		rreg("sticky kept", OFF_STKY, 32'h0000_0004);
		wreg(OFF_STKY, 32'h0000_0000);
		rreg("sticky clear", OFF_STKY, 32'h0000_0000);
	endtask : t_logic
	task automatic t_compare();
		wreg(hi(9), 32'h1234_5600);
		wreg(OFF_CMD, cmd(OP_COMP, 0, 1, 9));
		rreg("comp gt", OFF_ASTAT, 32'h8000_0000);
		wreg(OFF_CMD, cmd(OP_COMP, 1, 0, 9));
		rreg("comp lt", OFF_ASTAT, 32'h4000_0004);
		rreg("no result", hi(9), 32'h1234_5600);
		wreg(OFF_CMD, cmd(OP_PASS, 1, 0, 8));
		rreg("hist kept", OFF_ASTAT, 32'h4000_0000);
	endtask : t_compare
	task automatic t_regs();
		wreg(hi(1) + 12'h004, 32'h0000_00FF);
		wreg(OFF_CMD, cmd(OP_INC, 1, 0, 1));
		rreg("same reg", hi(1), 32'h0000_0002);
		wreg(OFF_CMD, cmd(OP_PASS, 1, 0, 8));
		rreg("upper only", hi(8), 32'h0000_0002);
		rreg("low zeroed", hi(8) + 12'h004, 32'h0000_0000);
		wreg(hi(10), 32'hFFFF_FFFF);
		wreg(hi(10) + 12'h004, 32'h0000_00FF);
		wreg(OFF_CMD, cmd(OP_FPASS, 10, 0, 11));
		rreg("nan sticky", OFF_STKY, 32'h0000_0020);
	endtask : t_regs
	task automatic t_float();
		wreg(hi(12), 32'h4060_0000);
		wreg(OFF_CMD, cmd(OP_FLOGB, 12, 0, 13));
		rreg("exponent_extract_op", hi(13), 32'h0000_0001);
		rreg("astat float", OFF_ASTAT, 32'h4000_0400);
		wreg(OFF_CMD, cmd(OP_FIX, 12, 0, 13));
		rreg("fix nearest", hi(13), 32'h0000_0004);
		wreg(OFF_MODE, MODE_RESET | 32'h0000_8000);
		wreg(OFF_CMD, cmd(OP_FIX, 12, 0, 13));
		rreg("fix to zero", hi(13), 32'h0000_0003);
	endtask : t_float
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : report_and_stop
	always #5 clk = ~clk;
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_sat();
		t_wrap();
		t_logic();
		t_compare();
		t_regs();
		t_float();
		report_and_stop();
	end
	initial begin
		#200000;
		fail_count++;
		report_and_stop();
	end
endmodule : testbench
